// file: design/sdct_pkg.sv
// package: timing constants and command codes shared by both ends
package sdct_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // faster grade, matching the 125 MHz clock
  localparam int ROW_TO_COLUMN_WAIT_NS = 16;
  localparam int BANK_TO_BANK_ACTIVATE_WAIT_NS = 16;
  localparam int MODE_SET_WAIT_NS = 16;
  localparam int ROW_CYCLE_NS = 70;
  localparam int POWER_DOWN_ENTRY_TIME_NS = 8;
  // unit not printed; taken as clock cycles
  localparam int SELF_REFRESH_EXIT_WAIT_CLK = 10;
  localparam int COLUMN_TO_COLUMN_WAIT_CLK = 1;
  localparam int READ_MASK_LATENCY_CLK = 2;
  localparam int WRITE_MASK_LATENCY_CLK = 0;
  localparam int SELF_REFRESH_EXIT_EDGE = 2;
  // least time: round up
  localparam int ROW_TO_COLUMN_WAIT_CLK =
    (ROW_TO_COLUMN_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BANK_TO_BANK_ACTIVATE_WAIT_CLK =
    (BANK_TO_BANK_ACTIVATE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MODE_SET_WAIT_CLK = (MODE_SET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_CYCLE_CLK = (ROW_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest time: round down, at least one cycle
  localparam int POWER_DOWN_ENTRY_CLK =
    (POWER_DOWN_ENTRY_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : POWER_DOWN_ENTRY_TIME_NS / CLK_PERIOD_NS;
  localparam int DATA_WIDTH = 8;
  localparam int ADDR_WIDTH = 13;
  localparam int CNT_WIDTH = 5;
  typedef enum logic [2:0] {
    SDCT_NOP, SDCT_ACT, SDCT_RD, SDCT_WR, SDCT_MRS, SDCT_REF, SDCT_PRE
  } sdct_cmd_type;
endpackage

// file: design/sdct_if.sv
// interface: command bus and data lines between controller and memory
`timescale 1ns/10ps
`default_nettype none
interface sdct_if;
  sdct_pkg::sdct_cmd_type cmd;
  logic [1:0]                       bank;
  logic [sdct_pkg::ADDR_WIDTH-1:0]  addr;
  logic                             cke;
  logic                             dqm;
  logic [sdct_pkg::DATA_WIDTH-1:0]  dq_ctl_out;
  logic                             dq_ctl_oe;
  logic [sdct_pkg::DATA_WIDTH-1:0]  dq_mem_out;
  logic                             dq_mem_oe;
  logic [sdct_pkg::DATA_WIDTH-1:0]  dq;
  assign dq = dq_mem_oe ? dq_mem_out : dq_ctl_out;
  modport ctl (output cmd, bank, addr, cke, dqm, dq_ctl_out, dq_ctl_oe, input dq);
  modport mem (input cmd, bank, addr, cke, dqm, dq_ctl_out, dq_ctl_oe,
               output dq_mem_out, dq_mem_oe);
endinterface
`default_nettype wire

// file: design/sdct_mem.sv
// memory end: command decode, data mask, self-refresh exit, power-down
`timescale 1ns/10ps
`default_nettype none
module sdct_mem (
  input  wire logic                            clk,          // system clock
  input  wire logic                            reset,        // sync reset, high
  sdct_if.mem                                  bus,          // command bus
  output logic                                 powered_down, // in power-down
  output logic                                 in_self_refresh, // in self refresh
  output logic                                 exit_started, // exit begun pulse
  output logic [sdct_pkg::DATA_WIDTH-1:0]      wr_data,      // written word
  output logic                                 wr_valid      // write accepted pulse
);
  logic [sdct_pkg::DATA_WIDTH-1:0] mem_ff [0:15];
  logic [sdct_pkg::DATA_WIDTH-1:0] rd_stage_ff;
  logic [sdct_pkg::DATA_WIDTH-1:0] rd_data_ff;
  logic [1:0]                      rd_pipe_ff;
  logic [1:0]                      mask_pipe_ff;
  logic                            cke_q_ff;
  logic [1:0]                      exit_cnt_ff;

  // column commands taken every cycle, no spacing check
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_valid <= 1'b0;
      wr_data  <= '0;
    end else begin
      // masked write data dropped the same cycle
      wr_valid <= (bus.cmd == sdct_pkg::SDCT_WR) && !bus.dqm && bus.cke && bus.dq_ctl_oe;
      wr_data  <= bus.dq_ctl_out;
      if ((bus.cmd == sdct_pkg::SDCT_WR) && !bus.dqm && bus.cke && bus.dq_ctl_oe) begin
        mem_ff[bus.addr[3:0]] <= bus.dq_ctl_out;
      end
    end
  end

  // read path; data, flag and mask all ride two stages so they meet at the pins
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_pipe_ff   <= 2'h0;
      mask_pipe_ff <= 2'h0;
      rd_stage_ff  <= '0;
      rd_data_ff   <= '0;
    end else begin
      rd_pipe_ff   <= {rd_pipe_ff[0], (bus.cmd == sdct_pkg::SDCT_RD) && bus.cke};
      mask_pipe_ff <= {mask_pipe_ff[0], bus.dqm};
      rd_stage_ff  <= mem_ff[bus.addr[3:0]];
      rd_data_ff   <= rd_stage_ff; // one stage only would hand out the next command's word
    end
  end
  assign bus.dq_mem_out = rd_data_ff;
  assign bus.dq_mem_oe  = rd_pipe_ff[1] && !mask_pipe_ff[1];

  // self refresh entry on refresh with cke low; exit on second edge after cke high
  always_ff @(posedge clk) begin
    if (reset) begin
      cke_q_ff        <= 1'b1;
      in_self_refresh <= 1'b0;
      exit_cnt_ff     <= 2'h0;
      exit_started    <= 1'b0;
    end else begin
      cke_q_ff     <= bus.cke;
      exit_started <= 1'b0;
      if (!in_self_refresh) begin
        in_self_refresh <= (bus.cmd == sdct_pkg::SDCT_REF) && !bus.cke;
        exit_cnt_ff     <= 2'h0;
      end else if (bus.cke) begin
        exit_cnt_ff <= exit_cnt_ff + 2'h1;
        if (exit_cnt_ff == 2'(sdct_pkg::SELF_REFRESH_EXIT_EDGE - 1)) begin
          in_self_refresh <= 1'b0;
          exit_started    <= 1'b1;
        end
      end else begin
        exit_cnt_ff <= 2'h0;
      end
    end
  end

  // power-down taken at the first edge with cke low, inside the entry time
  always_ff @(posedge clk) begin
    if (reset) begin
      powered_down <= 1'b0;
    end else begin
      powered_down <= !bus.cke && !in_self_refresh && (bus.cmd != sdct_pkg::SDCT_REF);
    end
  end
endmodule
`default_nettype wire

// file: design/sdct_ctl.sv
// controller end: spaces commands by the memory's minimum timings
// What this block does
// - activate to column waits row-to-column time
// - activates to other banks spaced apart
// - column commands may issue every cycle
// - nanosecond minimums round up to cycles
// - read mask disables outputs two cycles later
// - write mask drops same-cycle data
// - mode set waits before next command
// - self refresh exit on second edge
// - after exit wait one row cycle
// - observe self refresh exit minimum
// - power-down entered shortly after cke low
`timescale 1ns/10ps
`default_nettype none
module sdct_ctl (
  input  wire logic                            clk,       // system clock
  input  wire logic                            reset,     // sync reset, high
  sdct_if.ctl                                  bus,       // command bus
  input  wire sdct_pkg::sdct_cmd_type          req_cmd,   // requested command
  input  wire logic [1:0]                      req_bank,  // requested bank
  input  wire logic [sdct_pkg::ADDR_WIDTH-1:0] req_addr,  // requested address
  input  wire logic [sdct_pkg::DATA_WIDTH-1:0] req_wdata, // write data
  input  wire logic                            req_mask,  // data mask level
  input  wire logic                            req_valid, // request present
  output logic                                 req_ready, // request taken
  input  wire logic                            cke_req,   // wanted cke level
  output logic [sdct_pkg::DATA_WIDTH-1:0]      rd_data,   // sampled read bus
  output logic                                 busy       // mode-set, exit or activate-spacing wait running
);
  logic [sdct_pkg::CNT_WIDTH-1:0] rcd_ff [0:3];
  logic [sdct_pkg::CNT_WIDTH-1:0] rrd_ff;
  logic [sdct_pkg::CNT_WIDTH-1:0] all_ff;
  logic                           cke_ff;
  logic                           col_ok;
  logic                           may_go;

  // counts come from the package, already rounded up
  function automatic logic [sdct_pkg::CNT_WIDTH-1:0] dec(input logic [sdct_pkg::CNT_WIDTH-1:0] v);
    dec = (v == '0) ? v : v - 5'h01;
  endfunction

  assign col_ok = (rcd_ff[req_bank] == '0);
  // column commands need no gap of their own
  always_comb begin
    may_go = (all_ff == '0) && cke_ff;
    unique case (req_cmd)
      sdct_pkg::SDCT_ACT: may_go = may_go && (rrd_ff == '0);
      sdct_pkg::SDCT_RD,
      sdct_pkg::SDCT_WR:  may_go = may_go && col_ok;
      default:            may_go = may_go;
    endcase
  end
  assign req_ready = req_valid && may_go;
  assign busy      = (all_ff != '0) || (rrd_ff != '0);

  // drive command or nop while a wait runs
  always_ff @(posedge clk) begin
    if (reset) begin
      bus.cmd        <= sdct_pkg::SDCT_NOP;
      bus.bank       <= 2'h0;
      bus.addr       <= '0;
      bus.dq_ctl_out <= '0;
      bus.dq_ctl_oe  <= 1'b0;
      bus.dqm        <= 1'b0;
      rd_data        <= '0;
    end else begin
      bus.cmd       <= req_ready ? req_cmd : sdct_pkg::SDCT_NOP;
      bus.bank      <= req_bank;
      bus.addr      <= req_addr;
      bus.dq_ctl_out <= req_wdata;
      bus.dq_ctl_oe <= req_ready && (req_cmd == sdct_pkg::SDCT_WR);
      bus.dqm       <= req_mask; // mask reaches the memory timing
      rd_data       <= bus.dq;
    end
  end

  // cke follows the user; any rising cke, out of power-down or self refresh, arms the exit wait
  always_ff @(posedge clk) begin
    if (reset) begin
      cke_ff  <= 1'b1;
      bus.cke <= 1'b1;
    end else begin
      cke_ff  <= cke_req;
      bus.cke <= cke_req; // memory powers down on the edge after
    end
  end

  // waiting counters
  always_ff @(posedge clk) begin
    if (reset) begin
      rrd_ff <= '0;
      all_ff <= '0;
      for (int i = 0; i < 4; i++) begin
        rcd_ff[i] <= '0;
      end
    end else begin
      rrd_ff <= dec(rrd_ff);
      all_ff <= dec(all_ff);
      for (int i = 0; i < 4; i++) begin
        rcd_ff[i] <= dec(rcd_ff[i]);
      end
      if (req_ready && req_cmd == sdct_pkg::SDCT_ACT) begin
        rcd_ff[req_bank] <= 5'(sdct_pkg::ROW_TO_COLUMN_WAIT_CLK);
        rrd_ff <= 5'(sdct_pkg::BANK_TO_BANK_ACTIVATE_WAIT_CLK);
      end
      if (req_ready && req_cmd == sdct_pkg::SDCT_MRS) begin
        all_ff <= 5'(sdct_pkg::MODE_SET_WAIT_CLK);
      end
      // exit begins two edges after cke high; longer of row cycle and exit minimum, plus that lead
      if (cke_req && !cke_ff) begin
        all_ff <= 5'((sdct_pkg::ROW_CYCLE_CLK > sdct_pkg::SELF_REFRESH_EXIT_WAIT_CLK ?
                      sdct_pkg::ROW_CYCLE_CLK : sdct_pkg::SELF_REFRESH_EXIT_WAIT_CLK)
                     + sdct_pkg::SELF_REFRESH_EXIT_EDGE);
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/sdct_monitor.sv
// checker: command spacing and data mask timing seen on the bus
`timescale 1ns/10ps
`default_nettype none
module sdct_monitor (
  input wire logic                   clk,      // system clock
  input wire logic                   reset,    // sync reset, high
  input wire sdct_pkg::sdct_cmd_type cmd,      // bus command
  input wire logic [1:0]             bank,     // bus bank
  input wire logic                   cke,      // clock enable
  input wire logic                   dqm,      // data mask
  input wire logic                   dq_mem_oe,   // memory drives dq
  input wire logic                   powered_down // memory in power-down
);
  logic [4:0] up_cnt_ff; // cycles since cke returned high
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // saturated after reset so that ordinary traffic is not flagged
  always_ff @(posedge clk) begin
    if (reset)
      up_cnt_ff <= 5'h1F;
    else if (!cke)
      up_cnt_ff <= 5'h00;
    else if (up_cnt_ff != 5'h1F)
      up_cnt_ff <= up_cnt_ff + 5'h01;
  end
  row_col_a: assert property (cmd == sdct_pkg::SDCT_ACT |=>
    !((cmd == sdct_pkg::SDCT_RD || cmd == sdct_pkg::SDCT_WR) && bank == $past(bank)))
    else $error("column command too soon after activate");
  act_act_a: assert property (cmd == sdct_pkg::SDCT_ACT |=> cmd != sdct_pkg::SDCT_ACT)
    else $error("activates too close");
  mode_gap_a: assert property (cmd == sdct_pkg::SDCT_MRS |=> cmd == sdct_pkg::SDCT_NOP)
    else $error("command too soon after mode set");
  read_mask_a: assert property (cmd == sdct_pkg::SDCT_RD && cke |->
    ##2 dq_mem_oe == !$past(dqm, 2)) else $error("read mask latency wrong");
  oe_cause_a: assert property (dq_mem_oe |-> $past(cmd, 2) == sdct_pkg::SDCT_RD)
    else $error("data driven without read");
  exit_wait_a: assert property (cke && cmd != sdct_pkg::SDCT_NOP |-> up_cnt_ff >= 5'h0A)
    else $error("command during self refresh exit");
  exit_hold_a: assert property ($rose(cke) |-> cmd == sdct_pkg::SDCT_NOP [*8])
    else $error("exit minimum not kept");
  idle_nop_a: assert property (!cke && !$past(cke) |-> cmd == sdct_pkg::SDCT_NOP)
    else $error("command while clock disabled");
  pd_entry_a: assert property ($fell(cke) && cmd != sdct_pkg::SDCT_REF |=> powered_down)
    else $error("power-down not entered in time");
endmodule
`default_nettype wire

// file: dv/tb_sdram_command_timing.sv
// testbench: controller and memory joined, spacing and mask scenarios
`timescale 1ns/10ps
`default_nettype none
module tb_sdram_command_timing;
  logic                   clk, reset, req_valid, req_mask, cke_req, req_ready;
  logic                   powered_down, in_sr, exit_started, wr_valid;
  sdct_pkg::sdct_cmd_type req_cmd;
  logic [1:0]             req_bank;
  logic [12:0]            req_addr;
  logic [7:0]             req_wdata;
  int                     err_total, check_count, take;
  int                     cyc = 0, n_wr = 0, n_exit = 0;
  logic [7:0]             rq[$], rc[$], wq[$];
  logic [7:0]             rd_ctl, wr_mem;
  logic                   busy_w, first_busy;
  logic                   oe_d = 1'b0;
  sdct_if sdct_if_inst ();
  sdct_ctl sdct_ctl_inst (.clk(clk), .reset(reset), .bus(sdct_if_inst), .req_cmd(req_cmd),
    .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata), .req_mask(req_mask),
    .req_valid(req_valid), .req_ready(req_ready), .cke_req(cke_req), .rd_data(rd_ctl),
    .busy(busy_w));
  sdct_mem sdct_mem_inst (.clk(clk), .reset(reset), .bus(sdct_if_inst),
    .powered_down(powered_down), .in_self_refresh(in_sr), .exit_started(exit_started),
    .wr_data(wr_mem), .wr_valid(wr_valid));
  sdct_monitor sdct_monitor_inst (.clk(clk), .reset(reset), .cmd(sdct_if_inst.cmd),
    .bank(sdct_if_inst.bank), .cke(sdct_if_inst.cke), .dqm(sdct_if_inst.dqm),
    .dq_mem_oe(sdct_if_inst.dq_mem_oe), .powered_down(powered_down));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // cycle count plus a log of read data and write pulses seen at each edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sdct_if_inst.dq_mem_oe === 1'b1) rq.push_back(sdct_if_inst.dq);
    if (wr_valid === 1'b1) n_wr <= n_wr + 1;
    if (exit_started === 1'b1) n_exit <= n_exit + 1;
    // controller's sampled word lags the memory's drive window by one edge
    oe_d <= sdct_if_inst.dq_mem_oe;
    if (oe_d === 1'b1) rc.push_back(rd_ctl);
    if (wr_valid === 1'b1) wq.push_back(wr_mem);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // ready is looked at on the falling edge, where it has settled
  task automatic req(input sdct_pkg::sdct_cmd_type c, input logic [1:0] b,
                     input logic [3:0] a, input logic [7:0] d, input logic m);
    int k;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= 13'(a);
    req_wdata <= d;
    req_mask <= m;
    req_valid <= 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      k++;
      if (k == 1) first_busy = busy_w;
    end while (req_ready !== 1'b1 && k < 40);
    if (req_ready !== 1'b1) err_total++;
    take = cyc;
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    req_valid <= 1'b0;
    req_cmd <= sdct_pkg::SDCT_NOP;
    repeat (n) @(posedge clk);
  endtask
  task automatic s_write_read();
    int t0;
    req(sdct_pkg::SDCT_ACT, 2'h0, 4'h0, 8'h00, 1'b0);
    t0 = take;
    chk(8'(first_busy), 8'h00);
    req(sdct_pkg::SDCT_WR, 2'h0, 4'h5, 8'hA5, 1'b0);
    chk(8'(take - t0 >= sdct_pkg::ROW_TO_COLUMN_WAIT_CLK), 8'h01);
    req(sdct_pkg::SDCT_WR, 2'h0, 4'h6, 8'h5A, 1'b0);
    req(sdct_pkg::SDCT_WR, 2'h0, 4'h5, 8'h3C, 1'b1);
    req(sdct_pkg::SDCT_RD, 2'h0, 4'h5, 8'h00, 1'b0);
    t0 = take;
    req(sdct_pkg::SDCT_RD, 2'h0, 4'h6, 8'h00, 1'b0);
    chk(8'(take - t0), 8'h01);
    req(sdct_pkg::SDCT_RD, 2'h0, 4'h6, 8'h00, 1'b1);
    idle(8);
    chk(8'(n_wr), 8'h02);
    chk(8'(rq.size()), 8'h02);
    chk(rq[0], 8'hA5);
    chk(rq[1], 8'h5A);
    chk(8'(rc.size()), 8'h02);
    chk(rc[0], 8'hA5);
    chk(rc[1], 8'h5A);
    chk(8'(wq.size()), 8'h02);
    chk(wq[0], 8'hA5);
    chk(wq[1], 8'h5A);
  endtask
  task automatic s_spacing();
    int t0;
    req(sdct_pkg::SDCT_ACT, 2'h1, 4'h0, 8'h00, 1'b0);
    t0 = take;
    req(sdct_pkg::SDCT_ACT, 2'h2, 4'h0, 8'h00, 1'b0);
    chk(8'(take - t0 >= 2), 8'h01);
    req(sdct_pkg::SDCT_MRS, 2'h0, 4'h0, 8'h00, 1'b0);
    t0 = take;
    req(sdct_pkg::SDCT_ACT, 2'h3, 4'h0, 8'h00, 1'b0);
    chk(8'(take - t0 >= 2), 8'h01);
    chk(8'(first_busy), 8'h01);
    chk(8'(sdct_pkg::ROW_CYCLE_CLK), 8'h09);
    idle(2);
  endtask
  // cke and refresh go out together to enter self refresh
  task automatic s_self_refresh();
    int t0;
    int need;
    need = sdct_pkg::SELF_REFRESH_EXIT_EDGE + sdct_pkg::ROW_CYCLE_CLK;
    cke_req <= 1'b0;
    req(sdct_pkg::SDCT_REF, 2'h0, 4'h0, 8'h00, 1'b0);
    idle(4);
    // self refresh is a state of its own, not reported as power-down
    chk(8'(powered_down), 8'h00);
    chk(8'(in_sr), 8'h01);
    cke_req <= 1'b1;
    // cycle count at the edge where cke_req goes high
    t0 = take + 5;
    req(sdct_pkg::SDCT_ACT, 2'h0, 4'h0, 8'h00, 1'b0);
    chk(8'(take - t0 >= 10), 8'h01);
    chk(8'(take - t0 >= need), 8'h01);
    chk(8'(n_exit), 8'h01);
    chk(8'(in_sr), 8'h00);
    chk(8'(powered_down), 8'h00);
    idle(2);
  endtask
  // plain power-down: cke low with no refresh going out
  task automatic s_power_down();
    cke_req <= 1'b0;
    idle(3);
    chk(8'(powered_down), 8'h01);
    chk(8'(in_sr), 8'h00);
    cke_req <= 1'b1;
    req(sdct_pkg::SDCT_ACT, 2'h1, 4'h0, 8'h00, 1'b0);
    chk(8'(powered_down), 8'h00);
    chk(8'(n_exit), 8'h01);
    idle(2);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {reset, cke_req, req_valid, req_mask} = 4'hC;
    req_cmd = sdct_pkg::SDCT_NOP;
    {req_bank, req_addr, req_wdata} = 23'h000000;
    {err_total, check_count} = '0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    s_write_read();
    s_spacing();
    s_self_refresh();
    s_power_down();
    wrap_up();
  end
  // the run needs some hundred cycles; a hang is cut off well beyond that
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
